// file: verilog/csr_pkg.sv
package csr_pkg;

  // register offsets on the serial management port
  localparam logic [7:0] CSR_OFS_FAST = 8'h02;
  localparam logic [7:0] CSR_OFS_PRE_TERM = 8'h03;
  localparam logic [7:0] CSR_OFS_VOLT = 8'h04;

  // values after reset
  localparam logic [7:0] CSR_RST_FAST = 8'h60;
  localparam logic [7:0] CSR_RST_PRE_TERM = 8'h11;
  localparam logic [7:0] CSR_RST_VOLT = 8'hB2;

  // field positions
  localparam int CSR_FAST_RSV_BIT = 7;
  localparam int CSR_FAST_CODE_LSB = 2;
  localparam int CSR_COLD_BIT = 1;
  localparam int CSR_FORCE_BIT = 0;
  localparam int CSR_PRE_CODE_LSB = 4;
  localparam int CSR_PRE_TERM_RSV_BIT = 3;
  localparam int CSR_TERM_CODE_LSB = 0;
  localparam int CSR_REGULATION_VOLTAGE_CODE_CODE_LSB = 2;
  localparam int CSR_LOWBAT_BIT = 1;
  localparam int CSR_RECHG_BIT = 0;

  // writable bits per register; reserved bits are held at zero
  localparam logic [7:0] CSR_MASK_FAST = 8'h7F;
  localparam logic [7:0] CSR_MASK_PRE_TERM = 8'hF7;
  localparam logic [7:0] CSR_MASK_VOLT = 8'hFF;

  // analog scaling, currents in mA and voltages in mV
  localparam logic [15:0] CSR_FAST_OFS_MA = 16'h0200;
  localparam logic [15:0] CSR_FAST_STEP_MA = 16'h0040;
  localparam logic [15:0] CSR_PRE_STEP_MA = 16'h0080;
  localparam logic [3:0] CSR_PRE_SKIP_CODE = 4'h5;
  localparam logic [15:0] CSR_TERM_OFS_MA = 16'h0080;
  localparam logic [15:0] CSR_TERM_STEP_MA = 16'h0080;
  localparam logic [15:0] CSR_REGULATION_VOLTAGE_CODE_OFS_MV = 16'h0DB0;
  localparam logic [15:0] CSR_REGULATION_VOLTAGE_CODE_STEP_MV = 16'h0010;
  localparam logic [15:0] CSR_LOWBAT_LO_MV = 16'h0AF0;
  localparam logic [15:0] CSR_LOWBAT_HI_MV = 16'h0BB8;
  localparam logic [15:0] CSR_RECHG_LO_MV = 16'h0064;
  localparam logic [15:0] CSR_RECHG_HI_MV = 16'h012C;
  localparam logic [16:0] CSR_FAST_PCT = 17'h00014;
  localparam logic [16:0] CSR_PCT_FULL = 17'h00064;

  // the three stored registers
  typedef struct packed {
    logic [7:0] fast;
    logic [7:0] pre_term;
    logic [7:0] volt;
  } csr_regs_t;

  // setpoints handed to the analog charge loops
  typedef struct packed {
    logic [15:0] fast_ma;
    logic [15:0] precharge_ma;
    logic [15:0] term_ma;
    logic [15:0] reg_mv;
    logic [15:0] lowbat_mv;
    logic [15:0] recharge_mv;
    logic cold_sel;
  } csr_setpoint_t;

endpackage

// file: verilog/csr_decode.sv
module csr_decode
  import csr_pkg::*;
(
  input wire csr_regs_t regs,
  output csr_setpoint_t setp
);

  logic [4:0] fast_current_code;
  logic [3:0] precharge_current_code;
  logic [2:0] termination_current_code;
  logic [5:0] regulation_voltage_code;
  logic force_reduced_current;
  logic [15:0] fast_full;
  logic [15:0] precharge_current_value;
  logic [16:0] fast_scaled;

  assign fast_current_code = regs.fast[CSR_FAST_CODE_LSB +: 5];
  assign force_reduced_current = regs.fast[CSR_FORCE_BIT];
  assign precharge_current_code = regs.pre_term[CSR_PRE_CODE_LSB +: 4];
  assign termination_current_code = regs.pre_term[CSR_TERM_CODE_LSB +: 3];
  assign regulation_voltage_code = regs.volt[CSR_REGULATION_VOLTAGE_CODE_CODE_LSB +: 6];

  // binary weighted fast charge current over a fixed offset
  assign fast_full = 16'(CSR_FAST_OFS_MA + 16'(fast_current_code) * CSR_FAST_STEP_MA); // RULE2

  // table has a hole: code 5 jumps straight to 768 mA
  always_comb
  begin
    if (precharge_current_code == 4'h0) // RULE7
      precharge_current_value = CSR_PRE_STEP_MA;
    else if (precharge_current_code < CSR_PRE_SKIP_CODE)
      precharge_current_value = 16'(16'(precharge_current_code) * CSR_PRE_STEP_MA);
    else
      precharge_current_value = 16'((16'(precharge_current_code) + 16'h0001) * CSR_PRE_STEP_MA); // widen first, code 15 wraps in 4 bits
  end

  // reduced mode truncates toward zero
  assign fast_scaled = 17'((17'(fast_full) * CSR_FAST_PCT) / CSR_PCT_FULL);

  always_comb
  begin
    setp.fast_ma = force_reduced_current ? fast_scaled[15:0] : fast_full; // RULE6
    setp.precharge_ma = force_reduced_current ? (precharge_current_value >> 1) : precharge_current_value; // RULE6
    setp.term_ma = 16'(CSR_TERM_OFS_MA + 16'(termination_current_code) * CSR_TERM_STEP_MA); // RULE9
    setp.reg_mv = 16'(CSR_REGULATION_VOLTAGE_CODE_OFS_MV + 16'(regulation_voltage_code) * CSR_REGULATION_VOLTAGE_CODE_STEP_MV); // RULE10
    setp.lowbat_mv = regs.volt[CSR_LOWBAT_BIT] ? CSR_LOWBAT_HI_MV : CSR_LOWBAT_LO_MV; // RULE11
    setp.recharge_mv = regs.volt[CSR_RECHG_BIT] ? CSR_RECHG_HI_MV : CSR_RECHG_LO_MV; // RULE12
    setp.cold_sel = regs.fast[CSR_COLD_BIT]; // RULE5
  end

endmodule // csr_decode

// file: verilog/csr_setpoint_regs.sv
// Overview of operation
// RULE1: charge current top bit reserved, reads zero
// RULE2: fast current is 512 mA plus 64 mA steps
// RULE3: host keeps fast current at or below 2048
// RULE4: fast current code resets to 011000
// RULE5: cold select bit picks boost disable level
// RULE6: reduced mode gives 20% fast, 50% precharge
// RULE7: precharge code table with jump at 0101
// RULE8: precharge code resets to 0001
// RULE9: termination 128 mA offset, resets to 001
// RULE10: regulation voltage 3.504 V plus 16 mV steps
// RULE11: low battery threshold 2.8 or 3.0 V
// RULE12: recharge offset 100 or 300 mV
// RULE13: fields hold until written or reset
module csr_setpoint_regs
  import csr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_default_req,
  output logic [7:0] reg_rdata,
  output csr_setpoint_t setpoint
);

  csr_regs_t regs;
  csr_regs_t next_regs;
  logic [7:0] next_rdata;
  csr_setpoint_t next_setpoint;

  // writes land on the next edge; a register reset from the serial port wins
  always_comb
  begin
    next_regs = regs; // RULE13
    if (reg_default_req)
    begin
      next_regs.fast = CSR_RST_FAST; // RULE4
      next_regs.pre_term = CSR_RST_PRE_TERM; // RULE8
      next_regs.volt = CSR_RST_VOLT;
    end
    else if (reg_wr)
    begin
      if (reg_addr == CSR_OFS_FAST)
        next_regs.fast = reg_wdata & CSR_MASK_FAST; // RULE1
      else if (reg_addr == CSR_OFS_PRE_TERM)
        next_regs.pre_term = reg_wdata & CSR_MASK_PRE_TERM;
      else if (reg_addr == CSR_OFS_VOLT)
        next_regs.volt = reg_wdata & CSR_MASK_VOLT;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      regs.fast <= CSR_RST_FAST; // RULE4
      regs.pre_term <= CSR_RST_PRE_TERM; // RULE8
      regs.volt <= CSR_RST_VOLT;
    end
    else
      regs <= next_regs;
  end

  // read data registered one cycle after the address; unmapped reads zero
  always_comb
  begin
    if (reg_addr == CSR_OFS_FAST)
      next_rdata = regs.fast & CSR_MASK_FAST; // RULE1
    else if (reg_addr == CSR_OFS_PRE_TERM)
      next_rdata = regs.pre_term & CSR_MASK_PRE_TERM;
    else if (reg_addr == CSR_OFS_VOLT)
      next_rdata = regs.volt;
    else
      next_rdata = 8'h00;
  end

  // decode kept combinational, outputs retimed so the loops see clean levels
  csr_decode u_decode (
    .regs(regs),
    .setp(next_setpoint)
  );

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
      setpoint <= '0;
    end
    else
    begin
      reg_rdata <= next_rdata;
      setpoint <= next_setpoint;
    end
  end

  // helper: the setpoint register is valid only after one edge past reset
  logic sp_valid;
  logic next_sp_valid;
  always_comb
  begin
    next_sp_valid = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sp_valid <= 1'b0;
    else
      sp_valid <= next_sp_valid;
  end

  a_rsv_read_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
    $past(reg_addr) == CSR_OFS_FAST |-> reg_rdata[CSR_FAST_RSV_BIT] == 1'b0)
    else $error("reserved charge current bit read back as one");

  a_fast_offset: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE2
    sp_valid && !$past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.fast_ma == 16'(16'h0200 + 16'($past(regs.fast[6:2])) * 16'h0040))
    else $error("fast current does not match code");

  a_fast_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE4
    reg_default_req |=> regs.fast[6:2] == 5'b11000 ##1 (sp_valid -> setpoint.fast_ma == 16'h0800))
    else $error("fast current default wrong after register reset");

  a_cold_follow: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE5
    sp_valid |-> setpoint.cold_sel == $past(regs.fast[CSR_COLD_BIT]))
    else $error("cold select does not follow register");

  a_reduced_scale: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
    sp_valid && $past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.fast_ma == 16'((32'(16'h0200 + 16'($past(regs.fast[6:2])) * 16'h0040) * 20) / 100))
    else $error("reduced fast current not twenty percent");

  a_pre_jump: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE7
    sp_valid && $past(regs.pre_term[7:4]) == 4'h5 && !$past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.precharge_ma == 16'h0300)
    else $error("precharge code 0101 not 768 mA");

  a_pre_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE8
    reg_default_req |=> regs.pre_term == 8'h11)
    else $error("precharge default wrong");

  a_term_value: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE9
    sp_valid |-> setpoint.term_ma == 16'(16'h0080 + 16'($past(regs.pre_term[2:0])) * 16'h0080))
    else $error("termination current mismatch");

  a_regulation_voltage_code_value: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE10
    sp_valid |-> setpoint.reg_mv == 16'(16'h0DB0 + 16'($past(regs.volt[7:2])) * 16'h0010))
    else $error("regulation voltage mismatch");

  a_lowbat_sel: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE11
    sp_valid |-> setpoint.lowbat_mv == ($past(regs.volt[1]) ? 16'h0BB8 : 16'h0AF0))
    else $error("low battery threshold mismatch");

  a_rechg_sel: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE12
    sp_valid |-> setpoint.recharge_mv == ($past(regs.volt[0]) ? 16'h012C : 16'h0064))
    else $error("recharge offset mismatch");

  a_hold_value: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE13
    !reg_wr && !reg_default_req |=> $stable(regs))
    else $error("register changed without a write");

  // reserved bits never reach storage, not only masked on the read path
  a_rsv_stored_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
    regs.fast[CSR_FAST_RSV_BIT] == 1'b0 && regs.pre_term[CSR_PRE_TERM_RSV_BIT] == 1'b0)
    else $error("reserved bit stored as one");

  // each mapped write lands at its own edge
  a_wr_fast_lands: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE13
    reg_wr && !reg_default_req && reg_addr == CSR_OFS_FAST |=>
      regs.fast == ($past(reg_wdata) & 8'h7F))
    else $error("charge current write did not land");

  a_wr_pre_lands: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE13
    reg_wr && !reg_default_req && reg_addr == CSR_OFS_PRE_TERM |=>
      regs.pre_term == ($past(reg_wdata) & 8'hF7))
    else $error("precharge and termination write did not land");

  a_wr_volt_lands: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE13
    reg_wr && !reg_default_req && reg_addr == CSR_OFS_VOLT |=>
      regs.volt == $past(reg_wdata))
    else $error("charge voltage write did not land");

  // writes outside the map must leave every field alone
  a_unmapped_ignored: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE13
    reg_wr && !reg_default_req && reg_addr != CSR_OFS_FAST && reg_addr != CSR_OFS_PRE_TERM &&
      reg_addr != CSR_OFS_VOLT |=> $stable(regs))
    else $error("write to unmapped offset changed a register");

  a_rdata_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE1
    $past(reg_addr) != CSR_OFS_FAST && $past(reg_addr) != CSR_OFS_PRE_TERM &&
      $past(reg_addr) != CSR_OFS_VOLT |-> reg_rdata == 8'h00)
    else $error("unmapped offset read back nonzero");

  // register reset restores every remaining field
  a_cold_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE5
    reg_default_req |=> regs.fast[CSR_COLD_BIT] == 1'b0)
    else $error("cold select not cleared by register reset");

  a_force_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
    reg_default_req |=> regs.fast[CSR_FORCE_BIT] == 1'b0)
    else $error("reduced current bit not cleared by register reset");

  a_term_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE9
    reg_default_req |=> regs.pre_term[CSR_TERM_CODE_LSB +: 3] == 3'b001)
    else $error("termination code default wrong");

  a_regulation_voltage_code_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE10
    reg_default_req |=> regs.volt[CSR_REGULATION_VOLTAGE_CODE_CODE_LSB +: 6] == 6'b101100)
    else $error("regulation voltage default wrong");

  a_lowbat_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE11
    reg_default_req |=> regs.volt[CSR_LOWBAT_BIT] == 1'b1)
    else $error("low battery threshold default wrong");

  a_rechg_default: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE12
    reg_default_req |=> regs.volt[CSR_RECHG_BIT] == 1'b0)
    else $error("recharge offset default wrong");

  // precharge table end points and the halved value
  a_pre_halved: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE6
    sp_valid && $past(regs.pre_term[7:4]) == 4'h5 && $past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.precharge_ma == 16'h0180)
    else $error("reduced precharge not half of 768 mA");

  a_pre_low_codes: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE7
    sp_valid && $past(regs.pre_term[7:4]) < 4'h2 && !$past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.precharge_ma == 16'h0080)
    else $error("precharge codes 0000 and 0001 not 128 mA");

  a_pre_top_code: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE7
    sp_valid && $past(regs.pre_term[7:4]) == 4'hF && !$past(regs.fast[CSR_FORCE_BIT]) |->
      setpoint.precharge_ma == 16'h0800)
    else $error("precharge code 1111 not 2048 mA");

endmodule // csr_setpoint_regs

// file: sim/csr_host_model.sv
module csr_host_model
  import csr_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_default_req,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet port from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_default_req = 1'b0;
  end
  // one strobe, launched and dropped on falling edges so the rising edge sees it settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data must not matter once the strobe is gone
  endtask
  // read data is registered, so it is taken one full cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr <= a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // write and register reset in one cycle, the reset must win
  task automatic wr_def(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_default_req <= 1'b1;
    @(negedge clk_sys);
    reg_wr <= 1'b0;
    reg_default_req <= 1'b0;
  endtask
  // register reset request pulse
  task automatic soft_reset();
    @(negedge clk_sys);
    reg_default_req <= 1'b1;
    @(negedge clk_sys);
    reg_default_req <= 1'b0;
  endtask
endmodule // csr_host_model

// file: sim/tb_top.sv
module tb_top
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, f, p, v;
  logic reg_wr, reg_default_req;
  csr_setpoint_t setpoint;
  int failures, checks;
  csr_setpoint_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_default_req(reg_default_req), .reg_rdata(reg_rdata), .setpoint(setpoint));
  csr_host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_default_req(reg_default_req), .reg_rdata(reg_rdata));
  // 40 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // expected setpoints from the three register images
  function automatic csr_setpoint_t expect_setp(input logic [7:0] fr, input logic [7:0] pr, input logic [7:0] vr);
    csr_setpoint_t s;
    int fc, pc;
    fc = 512 + 64 * fr[6:2];
    pc = (pr[7:4] < 2) ? 128 : (pr[7:4] < 5) ? 128 * pr[7:4] : 128 * (pr[7:4] + 1);
    s.fast_ma = 16'(fr[0] ? fc * 20 / 100 : fc);
    s.precharge_ma = 16'(fr[0] ? pc / 2 : pc);
    s.term_ma = 16'(128 + 128 * pr[2:0]);
    s.reg_mv = 16'(3504 + 16 * vr[7:2]);
    s.lowbat_mv = vr[1] ? 16'h0BB8 : 16'h0AF0;
    s.recharge_mv = vr[0] ? 16'h012C : 16'h0064;
    s.cold_sel = fr[1];
    return s;
  endfunction
  // one compare, wide enough for the whole setpoint bundle
  task automatic check(input logic [96:0] seen, input logic [96:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // read back all three registers, then the decoded setpoints
  task automatic check_all(input logic [7:0] fr, input logic [7:0] pr, input logic [7:0] vr);
    i_host.rd(CSR_OFS_FAST, rv);
    check(97'(rv), 97'(fr & CSR_MASK_FAST));
    i_host.rd(CSR_OFS_PRE_TERM, rv);
    check(97'(rv), 97'(pr & CSR_MASK_PRE_TERM));
    i_host.rd(CSR_OFS_VOLT, rv);
    check(97'(rv), 97'(vr));
    check(setpoint, expect_setp(fr, pr, vr));
  endtask
  task automatic report_and_stop();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, far beyond the fewer than a thousand cycles the tests take
  initial
  begin
    #(20000 * 25);
    failures++;
    report_and_stop();
  end
  initial
  begin
    failures = 0;
    checks = 0;
    nrst = 1'b0;
    void'($urandom(32'hd7218c6e));
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    check_all(8'h60, 8'h11, 8'hB2);
    $display("test reset defaults done");
    // random settings, host keeps the fast code at or below 2048 mA
    repeat (60)
    begin
      f = {1'b0, 5'($urandom_range(24)), 2'($urandom)};
      p = 8'($urandom) & CSR_MASK_PRE_TERM;
      v = 8'($urandom);
      i_host.wr(CSR_OFS_FAST, f);
      i_host.wr(CSR_OFS_PRE_TERM, p);
      i_host.wr(CSR_OFS_VOLT, v);
      check_all(f, p, v);
    end
    $display("test random settings done");
    // reserved bits set, unmapped writes, then the soft reset
    i_host.wr(CSR_OFS_FAST, 8'hE3);
    i_host.wr(CSR_OFS_PRE_TERM, 8'hFF);
    i_host.wr(8'h05, 8'h00);
    i_host.wr(8'h01, 8'h00);
    check_all(8'h63, 8'hF7, v);
    i_host.soft_reset();
    check_all(8'h60, 8'h11, 8'hB2);
    $display("test reserved, unmapped and soft reset done");
    // corner codes, unmapped read, reset beating a write, reset in mid-run
    i_host.wr(CSR_OFS_FAST, 8'h81);
    i_host.wr(CSR_OFS_PRE_TERM, 8'hF0);
    check_all(8'h81, 8'hF0, 8'hB2);
    i_host.wr(CSR_OFS_FAST, 8'h00);
    check_all(8'h00, 8'hF0, 8'hB2);
    i_host.rd(8'h05, rv);
    check(97'(rv), 97'(8'h00));
    i_host.wr_def(CSR_OFS_FAST, 8'h7F);
    check_all(8'h60, 8'h11, 8'hB2);
    i_host.wr(CSR_OFS_FAST, 8'h81);
    @(negedge clk_sys);
    nrst = 1'b0;
    @(negedge clk_sys);
    check(setpoint, 97'(0));
    check(97'(reg_rdata), 97'(0));
    nrst = 1'b1;
    check_all(8'h60, 8'h11, 8'hB2);
    $display("test corner codes, default priority and mid-run reset done");
    report_and_stop();
  end
endmodule // tb_top
